// ==== rtl/cmp_ctrl_pkg.sv ====
// Package for the dual comparator control block.
// Assumes an 8-bit special function register port on the CPU clock.
`default_nettype none
package cmp_ctrl_pkg;
   localparam logic [7:0] ADDR_PORT0 = 8'h80;
   localparam logic [7:0] ADDR_MODE_A = 8'h84;
   localparam logic [7:0] ADDR_MODE_B = 8'h85;
   localparam logic [7:0] ADDR_CMP_ONE = 8'hAC;
   localparam logic [7:0] ADDR_CMP_TWO = 8'hAD;
   localparam logic [7:0] ADDR_AIN_DIS = 8'hF6;
   localparam logic [7:0] RESET_BYTE = 8'h00;
   // Control register field positions
   localparam int BIT_ENABLE = 5;
   localparam int BIT_POS_SEL = 4;
   localparam int BIT_NEG_SEL = 3;
   localparam int BIT_OUT_EN = 2;
   localparam int BIT_RESULT = 1;
   localparam int BIT_FLAG = 0;
   localparam logic [7:0] CTRL_WMASK = 8'h3D;
   // Settling time after enable, software obligation
   localparam int SETTLE_NS = 10000;
   localparam int CLK_NS = 10;
   localparam int SETTLE_CYC = SETTLE_NS / CLK_NS;

   typedef struct packed {
      logic wr;
      logic rd;
      logic [7:0] addr;
      logic [7:0] wdata;
   } sfr_req_t;
endpackage
`default_nettype wire

// ==== rtl/dual_comparator_control.sv ====
// Control and status logic for two analog comparators and port 0 gating.
// Assumes comparator analog outputs arrive synchronised to clk.
`timescale 1ns/1ps
`default_nettype none

module dual_comparator_control (
   // Clock and reset
   input wire logic clk,
   input wire logic resetn,
   // Special function register port
   input wire cmp_ctrl_pkg::sfr_req_t sfr_req,
   output logic [7:0] sfr_rdata,
   // Port 0 pins and analog front end
   input wire logic [7:0] port0_pin_in,
   output logic [7:0] port0_digital_in,
   input wire logic [1:0] analog_gt_pos_a,
   input wire logic [1:0] analog_gt_pos_b,
   output logic [1:0] analog_enable,
   output logic [1:0] pos_select,
   output logic [1:0] neg_select,
   // Comparator pins and interrupt controls
   output logic [1:0] cmp_pin_out,
   output logic [1:0] cmp_pin_oe,
   input wire logic [1:0] comparator_interrupt_enable,
   input wire logic global_interrupt_enable,
   output logic [1:0] cmp_irq,
   output logic cmp_wake
);
   logic [7:0] ain_dis_q;
   logic [7:0] mode_a_q;
   logic [7:0] mode_b_q;
   logic [7:0] port0_out_q;
   logic [7:0] ctrl_q [2];
   logic [1:0] result_q;
   logic [1:0] flag_q;
   logic [1:0] raw_result;

   // reset to zero, one bit per pin
   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         ain_dis_q <= cmp_ctrl_pkg::RESET_BYTE;
      end else if (sfr_req.wr && sfr_req.addr == cmp_ctrl_pkg::ADDR_AIN_DIS)
      begin
         ain_dis_q <= sfr_req.wdata;
      end
   end

   // Output mode bits are stored and read back only; no output port carries them
   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         mode_a_q <= cmp_ctrl_pkg::RESET_BYTE;
         mode_b_q <= cmp_ctrl_pkg::RESET_BYTE;
         port0_out_q <= cmp_ctrl_pkg::RESET_BYTE;
      end else if (sfr_req.wr) begin
         if (sfr_req.addr == cmp_ctrl_pkg::ADDR_MODE_A) begin
            mode_a_q <= sfr_req.wdata;
         end
         if (sfr_req.addr == cmp_ctrl_pkg::ADDR_MODE_B) begin
            mode_b_q <= sfr_req.wdata;
         end
         if (sfr_req.addr == cmp_ctrl_pkg::ADDR_PORT0) begin
            port0_out_q <= sfr_req.wdata;
         end
      end
   end

   assign port0_digital_in = port0_pin_in & ~ain_dis_q;

   generate
      for (genvar i = 0; i < 2; i++) begin : g_cmp
         logic [7:0] addr_i;
         logic wr_i;
         logic en_i;
         assign addr_i = (i == 0) ? cmp_ctrl_pkg::ADDR_CMP_ONE :
            cmp_ctrl_pkg::ADDR_CMP_TWO;
         assign wr_i = sfr_req.wr && sfr_req.addr == addr_i;
         assign en_i = ctrl_q[i][cmp_ctrl_pkg::BIT_ENABLE];

         always_ff @(posedge clk or negedge resetn) begin
            if (!resetn) begin
               ctrl_q[i] <= cmp_ctrl_pkg::RESET_BYTE;
            end else if (wr_i) begin
               ctrl_q[i] <= sfr_req.wdata & cmp_ctrl_pkg::CTRL_WMASK;
            end
         end

         // positive and negative input choice, configs
         assign pos_select[i] = ctrl_q[i][cmp_ctrl_pkg::BIT_POS_SEL];
         assign neg_select[i] = ctrl_q[i][cmp_ctrl_pkg::BIT_NEG_SEL];
         assign analog_enable[i] = en_i;
         // one only when positive exceeds negative
         assign raw_result[i] = en_i && (pos_select[i] ?
            analog_gt_pos_b[i] : analog_gt_pos_a[i]);

         always_ff @(posedge clk or negedge resetn) begin
            if (!resetn) begin
               result_q[i] <= 1'b0;
            end else begin
               result_q[i] <= raw_result[i];
            end
         end

         // set on change; write zero clears, set wins
         always_ff @(posedge clk or negedge resetn) begin
            if (!resetn) begin
               flag_q[i] <= 1'b0;
            end else if (raw_result[i] != result_q[i]) begin
               flag_q[i] <= 1'b1;
            end else if (wr_i && !sfr_req.wdata[cmp_ctrl_pkg::BIT_FLAG]) begin
               flag_q[i] <= 1'b0;
            end
         end

         assign cmp_pin_out[i] = result_q[i];
         assign cmp_pin_oe[i] = ctrl_q[i][cmp_ctrl_pkg::BIT_OUT_EN];
         assign cmp_irq[i] = flag_q[i] && comparator_interrupt_enable[i]
            && global_interrupt_enable;
      end
   endgenerate

   // wake request needs no running clock path beyond the gate
   assign cmp_wake = |cmp_irq;

   always_comb begin
      unique case (sfr_req.addr)
         cmp_ctrl_pkg::ADDR_PORT0: sfr_rdata = port0_digital_in;
         cmp_ctrl_pkg::ADDR_MODE_A: sfr_rdata = mode_a_q;
         cmp_ctrl_pkg::ADDR_MODE_B: sfr_rdata = mode_b_q;
         cmp_ctrl_pkg::ADDR_AIN_DIS: sfr_rdata = ain_dis_q;
         cmp_ctrl_pkg::ADDR_CMP_ONE: sfr_rdata = {ctrl_q[0][7:2],
            result_q[0], flag_q[0]};
         cmp_ctrl_pkg::ADDR_CMP_TWO: sfr_rdata = {ctrl_q[1][7:2],
            result_q[1], flag_q[1]};
         default: sfr_rdata = cmp_ctrl_pkg::RESET_BYTE;
      endcase
   end

   AST_PORT_GATE: assert property (
      @(posedge clk) disable iff (!resetn)
      (port0_digital_in & ain_dis_q) == '0)
      else $error("disabled port bit read as one");
   AST_AIN_WRITE: assert property (
      @(posedge clk) disable iff (!resetn)
      sfr_req.wr && sfr_req.addr == cmp_ctrl_pkg::ADDR_AIN_DIS
      |=> ain_dis_q == $past(sfr_req.wdata))
      else $error("input disable write lost");
   AST_RESULT_OFF: assert property (
      @(posedge clk) disable iff (!resetn)
      !analog_enable[0] |=> !result_q[0])
      else $error("disabled comparator shows one");
   AST_RESULT_OFF_TWO: assert property (
      @(posedge clk) disable iff (!resetn)
      !analog_enable[1] |=> !result_q[1])
      else $error("disabled comparator two shows one");
   AST_SEL_PIN_A: assert property (
      @(posedge clk) disable iff (!resetn)
      analog_enable[0] && !pos_select[0]
      |=> result_q[0] == $past(analog_gt_pos_a[0]))
      else $error("pin a choice not followed");
   AST_FLAG_SET: assert property (
      @(posedge clk) disable iff (!resetn)
      $changed(result_q[0]) |-> flag_q[0])
      else $error("change flag not set");
   AST_FLAG_SET_TWO: assert property (
      @(posedge clk) disable iff (!resetn)
      $changed(result_q[1]) |-> flag_q[1])
      else $error("change flag two not set");
   AST_FLAG_HOLD: assert property (
      @(posedge clk) disable iff (!resetn)
      flag_q[1] && !(sfr_req.wr && sfr_req.addr ==
      cmp_ctrl_pkg::ADDR_CMP_TWO) |=> flag_q[1])
      else $error("flag dropped without write");
   // Clear only counts when no change lands in the same cycle
   AST_FLAG_CLEAR: assert property (
      @(posedge clk) disable iff (!resetn)
      sfr_req.wr && sfr_req.addr == cmp_ctrl_pkg::ADDR_CMP_ONE
      && !sfr_req.wdata[cmp_ctrl_pkg::BIT_FLAG]
      && raw_result[0] == result_q[0] |=> !flag_q[0])
      else $error("flag not cleared by zero write");
   AST_IRQ: assert property (
      @(posedge clk) disable iff (!resetn)
      cmp_irq[0] == (flag_q[0] && comparator_interrupt_enable[0]
      && global_interrupt_enable))
      else $error("interrupt gating wrong");
   AST_PIN: assert property (
      @(posedge clk) disable iff (!resetn)
      analog_enable[1] && pos_select[1]
      |=> cmp_pin_out[1] == $past(analog_gt_pos_b[1]))
      else $error("pin does not follow result");
   AST_CTRL_WR: assert property (
      @(posedge clk) disable iff (!resetn)
      sfr_req.wr && sfr_req.addr == cmp_ctrl_pkg::ADDR_CMP_ONE
      |=> pos_select[0] == $past(sfr_req.wdata[cmp_ctrl_pkg::BIT_POS_SEL]))
      else $error("control write lost");
   AST_WAKE: assert property (
      @(posedge clk) disable iff (!resetn)
      cmp_wake == |cmp_irq)
      else $error("wake mismatch");

   // Main scenarios
   COV_IRQ: cover property (@(posedge clk) disable iff (!resetn)
      cmp_irq[0]);
   COV_CLEAR: cover property (@(posedge clk) disable iff (!resetn)
      flag_q[1] ##1 !flag_q[1]);
   COV_GATE: cover property (@(posedge clk) disable iff (!resetn)
      ain_dis_q == 8'h30);
   COV_IRQ_TWO: cover property (@(posedge clk) disable iff (!resetn)
      cmp_irq[1]);
   COV_PIN_ONE: cover property (@(posedge clk) disable iff (!resetn)
      cmp_pin_oe[0] && cmp_pin_out[0]);
endmodule // dual_comparator_control

`default_nettype wire

// ==== dv/dual_comparator_control_tb_top.sv ====
// Testbench for the dual comparator control block.
// Assumes one-cycle write strobes and reads that are combinational on addr.
`timescale 1ns/1ps
`default_nettype none
module dual_comparator_control_tb_top;
   logic clk = 1'b0;
   logic resetn = 1'b0;
   cmp_ctrl_pkg::sfr_req_t req = '0;
   logic [7:0] rdata;
   logic [7:0] pins = 8'hFF;
   logic [7:0] din;
   logic [1:0] gt_a = 2'h0;
   logic [1:0] gt_b = 2'h0;
   logic [1:0] ie = 2'h0;
   logic gie = 1'b0;
   logic [1:0] an_en, pos_sel, neg_sel, pin_out, pin_oe, irq;
   logic wake;
   int n_errors = 0;
   int cmp_count = 0;
   logic [7:0] addr_list [6] = '{8'h84, 8'h85, 8'hAC, 8'hAD, 8'hF6, 8'h3F};

   always #5 clk = ~clk;

   dual_comparator_control dut (.clk(clk), .resetn(resetn), .sfr_req(req),
      .sfr_rdata(rdata), .port0_pin_in(pins), .port0_digital_in(din),
      .analog_gt_pos_a(gt_a), .analog_gt_pos_b(gt_b),
      .analog_enable(an_en), .pos_select(pos_sel), .neg_select(neg_sel),
      .cmp_pin_out(pin_out), .cmp_pin_oe(pin_oe),
      .comparator_interrupt_enable(ie), .global_interrupt_enable(gie),
      .cmp_irq(irq), .cmp_wake(wake));

   task automatic chk(input logic [7:0] got, input logic [7:0] exp);
      cmp_count++;
      if (got !== exp) begin
         n_errors++;
         $display("wrong value at %0t: got %h expected %h", $time, got, exp);
      end
   endtask

   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      @(posedge clk);
      req <= '{wr: 1'b1, rd: 1'b0, addr: a, wdata: d};
      @(posedge clk);
      req.wr <= 1'b0;
   endtask

   // Read data is combinational, so sample just after the edge
   task automatic rd(input logic [7:0] a, input logic [7:0] exp);
      @(posedge clk);
      req.addr <= a;
      #1;
      chk(rdata, exp);
   endtask

   task automatic complete_run;
      $display("errors %0d, comparisons %0d", n_errors, cmp_count);
      if (n_errors == 0 && cmp_count > 0)
         $display("[ PASS ]");
      else
         $display("[ FAIL ]");
      $finish;
   endtask

   // Two settle waits dominate, plus about a hundred cycles
   initial begin
      repeat (3 * cmp_ctrl_pkg::SETTLE_CYC) @(posedge clk);
      n_errors++;
      complete_run;
   end

   initial begin
      logic [7:0] a;
      repeat (6) @(posedge clk);
      resetn <= 1'b1;
      foreach (addr_list[i]) rd(addr_list[i], 8'h00);
      wr(8'h3F, 8'hFF);
      rd(8'h3F, 8'h00);
      wr(8'hF6, 8'h30);
      rd(8'hF6, 8'h30);
      rd(8'h80, 8'hCF);
      chk(din, 8'hCF);
      wr(8'h84, 8'h30);
      rd(8'h84, 8'h30);
      wr(8'h85, 8'hCF);
      rd(8'h85, 8'hCF);
      // Every select and output combination on both comparators
      for (int j = 0; j < 2; j++) begin
         a = (j == 0) ? 8'hAC : 8'hAD;
         for (int c = 0; c < 8; c++) begin
            wr(a, {3'h1, c[2:0], 2'h0});
            #1;
            chk({4'h0, an_en[j], pos_sel[j], neg_sel[j], pin_oe[j]},
               {5'h01, c[2:0]});
            rd(a, {3'h1, c[2:0], 2'h0});
         end
      end
      wr(8'hAD, 8'h00);
      wr(8'hAC, 8'h24);
      @(posedge clk);
      gt_b <= 2'b01;
      // Output not trusted until the comparator has settled
      repeat (cmp_ctrl_pkg::SETTLE_CYC) @(posedge clk);
      rd(8'hAC, 8'h24);
      wr(8'hAC, 8'h24);
      @(posedge clk);
      ie <= 2'b01;
      gt_a <= 2'b01;
      rd(8'hAC, 8'h27);
      chk({6'h0, pin_out}, 8'h01);
      chk({5'h0, wake, irq}, 8'h00);
      @(posedge clk);
      gie <= 1'b1;
      #1;
      chk({5'h0, wake, irq}, 8'h05);
      wr(8'hAC, 8'h25);
      rd(8'hAC, 8'h27);
      wr(8'hAC, 8'h24);
      rd(8'hAC, 8'h26);
      chk({5'h0, wake, irq}, 8'h00);
      wr(8'hAD, 8'h34);
      repeat (cmp_ctrl_pkg::SETTLE_CYC) @(posedge clk);
      wr(8'hAD, 8'h34);
      @(posedge clk);
      gt_b <= 2'b10;
      ie <= 2'b10;
      rd(8'hAD, 8'h37);
      chk({5'h0, wake, irq}, 8'h06);
      complete_run;
   end
endmodule // dual_comparator_control_tb_top
`default_nettype wire
